// file: common/exc_pkg.sv
package exc_pkg;

  // vector table, one word per slot
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT = 32'h0000_000c;
  localparam logic [31:0] VEC_DABT = 32'h0000_0010;
  localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001c;
  // offset added to the data abort vector to form the link handed to a fast handler chained behind a data abort
  localparam logic [31:0] CHAIN_LINK_OFS = 32'h0000_0004;

  // mode encodings of the five-bit mode field
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;

  // status word layout
  localparam int SW_MODE_LSB = 0;
  localparam int SW_T_BIT = 5;
  localparam int SW_F_BIT = 6;
  localparam int SW_I_BIT = 7;
  localparam logic [31:0] SW_RESET_VAL = 32'h0000_00d3;

  // cycle figures
  localparam logic [1:0] DABT_ENTRY_CYC = 2'h3;
  localparam logic [1:0] FIQ_ENTRY_CYC = 2'h2;
  localparam logic [1:0] OTHER_ENTRY_CYC = 2'h2;
  localparam int SYNC_STAGES = 3;
  localparam int SYNC_MAX_CYC = 4;
  localparam logic [4:0] LDM_MAX_CYC = 5'h14;
  localparam logic [31:0] ADDR_STEP_WORD = 32'h0000_0004;
  localparam logic [31:0] ADDR_STEP_HALF = 32'h0000_0002;

  // register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_VEC = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0c;
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_FIQ_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h3;
  localparam int STAT_OVERRUN_BIT = 8;

  // pin positions on the synchroniser
  localparam int PIN_FIQ = 0;
  localparam int PIN_IRQ = 1;
  localparam int PIN_RST = 2;
  localparam int PIN_W = 3;

  typedef enum logic [2:0] {
    EK_NONE, EK_RESET, EK_UNDEF, EK_TRAP, EK_PABT, EK_DABT, EK_IRQ, EK_FIQ
  } exc_kind_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_RST_HOLD, ST_ENTRY
  } exc_state_t;

endpackage

// file: common/exc_sync_if.sv
`timescale 1ns/10ps
interface exc_sync_if #(
  parameter int W = 3
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface

// file: hw/exc_sync.sv
`timescale 1ns/10ps
module exc_sync #(
  parameter int W = 3,
  parameter int STAGES = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  exc_sync_if.sync_side port
);
  import exc_pkg::*;

  // idle level is high: all pins are active low
  logic [W-1:0] stage_r [STAGES];

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '1;
      end
    end else if (ce) begin
      stage_r[0] <= port.raw;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  // first two stages resolve metastability, the last one only delays
  assign port.synced = stage_r[STAGES-1];
endmodule

// file: hw/exc_unit.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module exc_unit #(
  parameter int SYNC_DEPTH = exc_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic fast_int_request_low,
  input wire logic normal_int_request_low,
  input wire logic reset_in_low,
  input wire logic insn_boundary,
  input wire logic undef_hit,
  input wire logic software_trap,
  input wire logic prefetch_abort_hit,
  input wire logic data_abort_hit,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] pipe_addr,
  input wire logic pipe_mreq_low,
  input wire logic pipe_seq,
  input wire logic status_wr,
  input wire logic [31:0] status_wdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic entry_valid,
  output exc_pkg::exc_kind_t entry_kind,
  output logic [31:0] entry_vector,
  output logic [31:0] entry_link,
  output logic [31:0] entry_saved_status,
  output logic flush,
  output logic [31:0] current_status_word,
  output logic [31:0] supervisor_saved_status,
  output logic [31:0] supervisor_link_register,
  output logic mem_request_low,
  output logic sequential_flag,
  output logic [31:0] addr_out
);
  import exc_pkg::*;

  exc_sync_if #(.W(PIN_W)) pins ();

  assign pins.raw[PIN_FIQ] = fast_int_request_low;
  assign pins.raw[PIN_IRQ] = normal_int_request_low;
  assign pins.raw[PIN_RST] = reset_in_low;

  exc_sync #(.W(PIN_W), .STAGES(SYNC_DEPTH)) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .port(pins.sync_side)
  );

  // synchronised levels, active high from here on
  logic fiq_s;
  logic irq_s;
  logic rst_s;
  assign fiq_s = ~pins.synced[PIN_FIQ];
  assign irq_s = ~pins.synced[PIN_IRQ];
  assign rst_s = ~pins.synced[PIN_RST];

  exc_state_t state_r;
  exc_kind_t kind_r;
  logic [1:0] cnt_r;
  logic chain_fiq_r;
  logic [31:0] sw_r;
  logic [31:0] link_hold_r;
  logic [1:0] ctrl_r;
  logic overrun_r;
  logic [4:0] wait_r;
  logic [31:0] entry_cnt_r;

  function automatic logic [31:0] vector_of(exc_kind_t k);
    case (k)
      EK_UNDEF: vector_of = VEC_UNDEF;
      EK_TRAP: vector_of = VEC_TRAP;
      EK_PABT: vector_of = VEC_PABT;
      EK_DABT: vector_of = VEC_DABT;
      EK_IRQ: vector_of = VEC_IRQ;
      EK_FIQ: vector_of = VEC_FIQ;
      default: vector_of = VEC_RESET;
    endcase
  endfunction

  function automatic logic [4:0] mode_of(exc_kind_t k);
    case (k)
      EK_UNDEF: mode_of = MODE_UND;
      EK_PABT, EK_DABT: mode_of = MODE_ABT;
      EK_IRQ: mode_of = MODE_IRQ;
      EK_FIQ: mode_of = MODE_FIQ;
      default: mode_of = MODE_SVC;
    endcase
  endfunction

  function automatic logic [1:0] cycles_of(exc_kind_t k);
    case (k)
      EK_DABT: cycles_of = DABT_ENTRY_CYC;
      EK_FIQ: cycles_of = FIQ_ENTRY_CYC;
      default: cycles_of = OTHER_ENTRY_CYC;
    endcase
  endfunction

  // status word as it stands after entry for kind k
  function automatic logic [31:0] entry_sw(logic [31:0] sw, exc_kind_t k);
    logic [31:0] v;
    v = sw;
    v[SW_MODE_LSB +: 5] = mode_of(k);
    v[SW_I_BIT] = 1'b1;
    if (k == EK_FIQ || k == EK_RESET) begin
      v[SW_F_BIT] = 1'b1;
    end
    // exceptions always run in the full-width state
    v[SW_T_BIT] = 1'b0;
    entry_sw = v;
  endfunction

  logic fiq_ok;
  logic irq_ok;
  exc_kind_t pick;

  // the status disable bit and the software enable must both allow
  assign fiq_ok = fiq_s && !sw_r[SW_F_BIT] && ctrl_r[CTRL_FIQ_EN_BIT];
  assign irq_ok = irq_s && !sw_r[SW_I_BIT] && ctrl_r[CTRL_IRQ_EN_BIT];

  always_comb begin
    // fast ahead of normal: a busy fast source can starve normal
    if (data_abort_hit) begin
      pick = EK_DABT;
    end else if (fiq_ok) begin
      pick = EK_FIQ;
    end else if (irq_ok) begin
      pick = EK_IRQ;
    end else if (prefetch_abort_hit) begin
      pick = EK_PABT;
    end else if (undef_hit) begin
      pick = EK_UNDEF;
    end else if (software_trap) begin
      pick = EK_TRAP;
    end else begin
      pick = EK_NONE;
    end
  end

  // exception sequencing and the status word
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_RUN;
      kind_r <= EK_NONE;
      cnt_r <= 2'h0;
      chain_fiq_r <= 1'b0;
      sw_r <= SW_RESET_VAL;
      link_hold_r <= 32'h0000_0000;
      entry_valid <= 1'b0;
      entry_kind <= EK_NONE;
      entry_vector <= VEC_RESET;
      entry_link <= 32'h0000_0000;
      entry_saved_status <= 32'h0000_0000;
      flush <= 1'b0;
      supervisor_saved_status <= 32'h0000_0000;
      supervisor_link_register <= 32'h0000_0000;
      entry_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      entry_valid <= 1'b0;
      flush <= 1'b0;
      if (rst_s) begin
        // current instruction is dropped for as long as reset is held
        state_r <= ST_RST_HOLD;
        chain_fiq_r <= 1'b0;
        // flush once, on the first held cycle
        flush <= (state_r != ST_RST_HOLD);
      end else begin
        case (state_r)
          ST_RST_HOLD: begin
            // pc and status are indeterminate here and banked as found
            supervisor_link_register <= pc_in;
            supervisor_saved_status <= sw_r;
            sw_r <= entry_sw(sw_r, EK_RESET);
            entry_valid <= 1'b1;
            entry_kind <= EK_RESET;
            entry_vector <= VEC_RESET;
            entry_link <= pc_in;
            entry_saved_status <= sw_r;
            entry_cnt_r <= entry_cnt_r + 32'h1;
            state_r <= ST_RUN;
          end
          ST_RUN: begin
            if (insn_boundary && pick != EK_NONE) begin
              kind_r <= pick;
              // counts down to zero, entry lands cycles_of edges later
              cnt_r <= cycles_of(pick) - 2'h1;
              chain_fiq_r <= (pick == EK_DABT) && fiq_ok;
              link_hold_r <= pc_in;
              flush <= 1'b1;
              state_r <= ST_ENTRY;
            end else if (status_wr) begin
              // a status write loses to an entry taken in the same cycle
              sw_r <= status_wdata;
            end
          end
          ST_ENTRY: begin
            if (cnt_r != 2'h0) begin
              cnt_r <= cnt_r - 2'h1;
            end else begin
              sw_r <= entry_sw(sw_r, kind_r);
              entry_valid <= 1'b1;
              entry_kind <= kind_r;
              entry_vector <= vector_of(kind_r);
              entry_link <= link_hold_r;
              entry_saved_status <= sw_r;
              entry_cnt_r <= entry_cnt_r + 32'h1;
              // a trap also banks its return state for the supervisor
              if (kind_r == EK_TRAP) begin
                supervisor_link_register <= link_hold_r;
                supervisor_saved_status <= sw_r;
              end
              if (chain_fiq_r) begin
                // fast handler returns into the abort handler's first word
                kind_r <= EK_FIQ;
                cnt_r <= FIQ_ENTRY_CYC - 2'h1;
                link_hold_r <= VEC_DABT + CHAIN_LINK_OFS;
                chain_fiq_r <= 1'b0;
              end else begin
                state_r <= ST_RUN;
              end
            end
          end
          default: begin
            state_r <= ST_RUN;
          end
        endcase
      end
    end
  end

  assign current_status_word = sw_r;

  // a write lands only at the access edge that also sees pready
  logic apb_setup;
  logic apb_wr;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;

  // memory request signals and address
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_request_low <= 1'b1;
      sequential_flag <= 1'b0;
      addr_out <= VEC_RESET;
    end else if (ce) begin
      if (state_r == ST_RST_HOLD && rst_s) begin
        // keeps stepping as if fetching, but memory must not commit
        mem_request_low <= 1'b1;
        sequential_flag <= 1'b0;
        addr_out <= addr_out + (sw_r[SW_T_BIT] ? ADDR_STEP_HALF : ADDR_STEP_WORD);
      end else if (state_r == ST_RST_HOLD) begin
        mem_request_low <= 1'b1;
        sequential_flag <= 1'b0;
        addr_out <= VEC_RESET;
      end else begin
        mem_request_low <= pipe_mreq_low;
        sequential_flag <= pipe_seq;
        addr_out <= pipe_addr;
      end
    end
  end

  // boundary watchdog: an enabled request waiting longer than the
  // longest instruction points at a stalled pipeline or wait states
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_r <= 5'h0;
      overrun_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_RUN && (fiq_ok || irq_ok) && !insn_boundary) begin
        // saturates so a long stall cannot wrap under the limit
        if (wait_r != 5'h1f) begin
          wait_r <= wait_r + 5'h1;
        end
      end else begin
        wait_r <= 5'h0;
      end
      // set wins over a clear in the same cycle
      if (wait_r >= LDM_MAX_CYC) begin
        overrun_r <= 1'b1;
      end else if (apb_wr && paddr == REG_STAT && pwdata[STAT_OVERRUN_BIT]) begin
        overrun_r <= 1'b0;
      end
    end
  end

  // status readback also shows the synchronised request levels
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      REG_CTRL: rd_val = {30'h0, ctrl_r};
      REG_STAT: rd_val = {21'h0, irq_s, fiq_s, overrun_r, sw_r[SW_F_BIT],
                          sw_r[SW_I_BIT], entry_kind, 1'b0, state_r};
      REG_VEC: rd_val = entry_vector;
      REG_CNT: rd_val = entry_cnt_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // apb slave: answer is computed in setup, so access needs no wait
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RESET_VAL;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
      // pslverr only answers the access cycle of an unmapped offset
      pslverr <= apb_setup && !rd_hit;
      prdata <= (apb_setup && !pwrite) ? rd_val : 32'h0000_0000;
      if (apb_wr && paddr == REG_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

endmodule

// file: sim/exc_exp_pkg.sv
package exc_exp_pkg;
  import exc_pkg::*;

  function automatic logic [31:0] vec_of(exc_kind_t k);
    case (k)
      EK_UNDEF: return VEC_UNDEF;
      EK_TRAP: return VEC_TRAP;
      EK_PABT: return VEC_PABT;
      EK_DABT: return VEC_DABT;
      EK_IRQ: return VEC_IRQ;
      EK_FIQ: return VEC_FIQ;
      default: return VEC_RESET;
    endcase
  endfunction

  function automatic logic [4:0] mode_of(exc_kind_t k);
    case (k)
      EK_UNDEF: return MODE_UND;
      EK_PABT, EK_DABT: return MODE_ABT;
      EK_IRQ: return MODE_IRQ;
      EK_FIQ: return MODE_FIQ;
      default: return MODE_SVC;
    endcase
  endfunction
endpackage

// file: sim/exc_pipe_model.sv
`timescale 1ns/10ps
module exc_pipe_model #(
  parameter int LEN = 4
) (
  input wire logic clk,
  input wire logic srst,
  output logic insn_boundary,
  output logic [31:0] pc_in,
  output logic [31:0] pipe_addr,
  output logic pipe_mreq_low,
  output logic pipe_seq
);
  logic [3:0] cnt_r;

  // fixed-length instructions keep entry timing predictable
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 4'h0;
      insn_boundary <= 1'b0;
      pipe_addr <= 32'h0;
      pipe_mreq_low <= 1'b0;
      pipe_seq <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 4'(LEN - 1)) ? 4'h0 : cnt_r + 4'h1;
      insn_boundary <= (cnt_r == 4'(LEN - 1));
      pipe_addr <= pipe_addr + 32'h4;
      pipe_mreq_low <= 1'b0;
      pipe_seq <= (cnt_r != 4'h0);
    end
  end
  assign pc_in = pipe_addr;
endmodule

// file: sim/exc_unit_assertions.sv
`timescale 1ns/10ps
module exc_unit_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_in_low,
  input wire logic entry_valid,
  input wire exc_pkg::exc_kind_t entry_kind,
  input wire logic [31:0] entry_vector,
  input wire logic flush,
  input wire logic [31:0] current_status_word,
  input wire logic mem_request_low,
  input wire logic sequential_flag,
  input wire logic [31:0] addr_out
);
  import exc_pkg::*;
  import exc_exp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  vec_map_a: assert property (entry_valid |-> entry_vector == vec_of(entry_kind))
    else $error("entry vector does not match kind");
  rsvd_slot_a: assert property (entry_valid |-> entry_vector != VEC_RSVD)
    else $error("reserved vector used");
  mode_entry_a: assert property (entry_valid |-> current_status_word[4:0] == mode_of(entry_kind))
    else $error("wrong mode on entry");
  i_set_a: assert property (entry_valid |-> current_status_word[SW_I_BIT])
    else $error("normal disable bit not set on entry");
  f_keep_a: assert property (entry_valid && !(entry_kind inside {EK_RESET, EK_FIQ})
    |-> current_status_word[SW_F_BIT] == $past(current_status_word[SW_F_BIT]))
    else $error("fast disable bit changed");
  short_entry_a: assert property (entry_valid && entry_kind inside {EK_IRQ, EK_PABT}
    |-> $past(flush, 2)) else $error("two-cycle entry timing off");
  dabt_entry_a: assert property (entry_valid && entry_kind == EK_DABT |-> $past(flush, 3))
    else $error("data abort entry timing off");
  // six low cycles cover the pin synchroniser and the output register
  rst_internal_a: assert property ((!reset_in_low) [*6] |-> mem_request_low && !sequential_flag)
    else $error("no internal cycle during reset");
  rst_addr_a: assert property ((!reset_in_low) [*7] |-> addr_out == $past(addr_out) +
    (current_status_word[SW_T_BIT] ? ADDR_STEP_HALF : ADDR_STEP_WORD))
    else $error("address not advancing during reset");
  rst_exit_a: assert property (entry_valid && entry_kind == EK_RESET
    |-> current_status_word[7:0] == 8'hd3 && addr_out == 32'h0)
    else $error("reset exit state wrong");
endmodule

bind exc_unit exc_unit_checker chk_i (.clk(clk), .srst(srst), .reset_in_low(reset_in_low),
  .entry_valid(entry_valid), .entry_kind(entry_kind), .entry_vector(entry_vector),
  .flush(flush), .current_status_word(current_status_word), .mem_request_low(mem_request_low),
  .sequential_flag(sequential_flag), .addr_out(addr_out));

// file: sim/exc_unit_tb_top.sv
`timescale 1ns/10ps
module exc_unit_tb_top;
  import exc_pkg::*;
  import exc_exp_pkg::*;
  logic clk, srst, reset_in_low, insn_boundary, pipe_mreq_low, pipe_seq, status_wr;
  logic psel, penable, pwrite, pready, pslverr, entry_valid, flush, e;
  logic mem_request_low, sequential_flag;
  logic [1:0] pins;
  logic [3:0] hits;
  logic [7:0] paddr;
  logic [19:0] row;
  logic [31:0] pc_in, pipe_addr, status_wdata, pwdata, prdata, entry_vector, entry_link, r;
  logic [31:0] current_status_word, supervisor_saved_status, addr_out, svc_link, saved_sw;
  exc_kind_t entry_kind, k;
  int n_mismatch, checks_done, n;
  // {status[7:0], hits dabt/pabt/trap/undef, pins fiq/irq, expected kind}
  logic [19:0] rows [9] = '{20'h10102, 20'h50203, 20'h10504, 20'h10416, 20'h10037,
    20'h50036, 20'h90414, 20'h10815, 20'h10825};

  exc_unit uut (.clk(clk), .srst(srst), .ce(1'b1), .fast_int_request_low(~pins[1]),
    .normal_int_request_low(~pins[0]), .reset_in_low(reset_in_low),
    .insn_boundary(insn_boundary), .undef_hit(hits[0]), .software_trap(hits[1]),
    .prefetch_abort_hit(hits[2]), .data_abort_hit(hits[3]), .pc_in(pc_in),
    .pipe_addr(pipe_addr), .pipe_mreq_low(pipe_mreq_low), .pipe_seq(pipe_seq),
    .status_wr(status_wr), .status_wdata(status_wdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .entry_valid(entry_valid), .entry_kind(entry_kind),
    .entry_vector(entry_vector), .entry_link(entry_link), .entry_saved_status(saved_sw),
    .flush(flush), .current_status_word(current_status_word),
    .supervisor_saved_status(supervisor_saved_status), .supervisor_link_register(svc_link),
    .mem_request_low(mem_request_low), .sequential_flag(sequential_flag),
    .addr_out(addr_out));

  exc_pipe_model pipe_m (.clk(clk), .srst(srst), .insn_boundary(insn_boundary), .pc_in(pc_in),
    .pipe_addr(pipe_addr), .pipe_mreq_low(pipe_mreq_low), .pipe_seq(pipe_seq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // sampled on the falling edge so registered pulses have settled
  task automatic wait_ev(input bit use_flush, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((use_flush ? flush : entry_valid) !== 1'b1 && n < lim);
    chk({31'h0, use_flush ? flush : entry_valid}, 32'h1);
  endtask

  // hits follow the status write so the write lands before any boundary sees them
  task automatic set_status(input logic [31:0] v, input logic [3:0] h);
    @(posedge clk) {status_wr, status_wdata} <= {1'b1, v};
    @(posedge clk) {status_wr, hits} <= {1'b0, h};
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    {srst, reset_in_low, psel, penable, pwrite, status_wr} = 6'b110000;
    {paddr, pwdata, status_wdata, hits, pins} = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r, {30'h0, CTRL_RESET_VAL});
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    for (int j = 0; j < 9; j++) begin
      row = rows[j];
      k = exc_kind_t'(row[2:0]);
      // requests settle through the synchroniser while still masked
      set_status(32'hd0, 4'h0);
      pins <= row[5:4];
      repeat (6) @(posedge clk);
      set_status({24'h0, row[19:12]}, row[11:8]);
      wait_ev(1'b1, 40);
      @(posedge clk) hits <= 4'h0;
      wait_ev(1'b0, 10);
      chk({29'h0, entry_kind}, {29'h0, k});
      chk(entry_vector, vec_of(k));
      chk({27'h0, current_status_word[4:0]}, {27'h0, mode_of(k)});
      chk({30'h0, current_status_word[7:6]}, {30'h0, 1'b1, (k == EK_FIQ) | row[18]});
      if (row[11] && row[5]) begin
        wait_ev(1'b0, 6);
        chk(32'(n), 32'h2);
        chk({29'h0, entry_kind}, {29'h0, EK_FIQ});
        chk(entry_link, 32'h14);
      end
      @(posedge clk) pins <= 2'b00;
      repeat (8) @(posedge clk);
    end
    apb(1'b0, REG_CNT, 32'h0);
    chk(r, 32'ha);
    apb(1'b0, REG_VEC, 32'h0);
    chk(r, VEC_FIQ);
    set_status(32'h10, 4'h0);
    @(posedge clk) reset_in_low <= 1'b0;
    repeat (10) @(negedge clk);
    chk({30'h0, mem_request_low, sequential_flag}, 32'h2);
    @(posedge clk) reset_in_low <= 1'b1;
    wait_ev(1'b0, 20);
    chk({29'h0, entry_kind}, {29'h0, EK_RESET});
    chk(entry_vector, VEC_RESET);
    chk(addr_out, VEC_RESET);
    chk({24'h0, current_status_word[7:0]}, 32'hd3);
    chk(supervisor_saved_status, 32'h10);
    chk(saved_sw, 32'h10);
    chk(svc_link, pipe_addr - 32'h4);
    chk(entry_link, pipe_addr - 32'h4);
    finish_test;
  end
endmodule
